// file: core/aopc_defs.svh
// Register offsets, field positions, reset values for output control
`ifndef AOPC_DEFS_SVH
`define AOPC_DEFS_SVH
`define AOPC_NCH 2
`define AOPC_A_CTRL 8'h00
`define AOPC_A_STAT 8'h04
`define AOPC_A_MASK 8'h08
`define AOPC_A_COMM 8'h0c
`define AOPC_CH_BASE 4'h1
`define AOPC_O_CFG 4'h0
`define AOPC_O_UPR 4'h4
`define AOPC_O_LWR 4'h8
`define AOPC_O_SAFE 4'hc
`define AOPC_CTRL_SCMON 0
`define AOPC_CTRL_FMT 1
`define AOPC_CTRL_HTPRIO 3
`define AOPC_CTRL_RST 4'h1
`define AOPC_CFG_RANGE 0
`define AOPC_CFG_UPEN 3
`define AOPC_CFG_LOEN 4
`define AOPC_CFG_FLTEN 5
`define AOPC_CFG_IDLEN 6
`define AOPC_CFG_RST 7'h00
`define AOPC_UPR_RST 16'h03e8
`define AOPC_LWR_RST 16'h0000
`define AOPC_UPR_MIN 16'h8002
`define AOPC_LWR_MAX 16'h7ffe
`define AOPC_ST_SC 0
`define AOPC_ST_UP 1
`define AOPC_ST_LO 3
`define AOPC_ST_W 5
`define AOPC_OBIN_MID 17'sh08000
`define AOPC_DAC_TOP 16'hffff
`endif

// file: core/aopc_pkg.sv
// Types shared by the analogue output control block
package aopc_pkg;
  typedef enum logic [2:0] {
    aopc_r_0_10v, aopc_r_0_5v, aopc_r_1_5v, aopc_r_0_20ma, aopc_r_4_20ma
  } aopc_range_e;
  typedef enum logic [1:0] {
    aopc_f_obin, aopc_f_signmag, aopc_f_twos, aopc_f_scaled
  } aopc_fmt_e;
  typedef logic signed [16:0] aopc_val_t;
endpackage

// file: core/aopc_core.sv
// Analogue output parameter control with Wishbone register slave
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "aopc_defs.svh"

// What this block does
// - Enabled short monitor raises one unit error
// - Five ranges per channel, default 0-10 V
// - Word format selectable, scaled turns limits
// - Enabled upper check flags channel overshoot
// - Enabled lower check flags channel undershoot
// - Scaled upper limit -32766..32767, default 1000
// - Scaled lower limit -32768..32766, default 0
// - Comm fault drives fault value or holds
// - Comm idle drives idle value or holds
// - Fault/idle options need handheld priority setting
module aopc_core import aopc_pkg::*; (
  input wire logic clk, // 50 MHz clock
  input wire logic rst, // Synchronous reset, high
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Bus write
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Bus acknowledge
  input wire logic sc_detect, // Output device short seen
  input wire logic comm_fault, // Link abnormal
  input wire logic comm_idle, // Master idling
  input wire logic [1:0][15:0] plc_word, // Output words from master
  output logic [1:0][15:0] dac_code, // Code, 0 = range bottom
  output logic [1:0][2:0] ch_range, // Selected output range
  output logic diag_unit, // Unit-wide short error
  output logic [1:0] diag_upper, // Per-channel upper error
  output logic [1:0] diag_lower, // Per-channel lower error
  output logic irq // Unmasked status pending
);
  localparam int NCH = `AOPC_NCH;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] o,
                                       input logic [31:0] n,
                                       input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic aopc_val_t to_val(input logic [15:0] w,
                                       input aopc_fmt_e f);
    aopc_val_t m;
    m = $signed({2'b00, w[14:0]});
    unique case (f)
      aopc_f_obin: to_val = $signed({1'b0, w}) - `AOPC_OBIN_MID;
      aopc_f_signmag: to_val = w[15] ? -m : m;
      aopc_f_twos, aopc_f_scaled: to_val = $signed({w[15], w});
    endcase
  endfunction

  // Scaled words map the lower..upper span onto the full code span
  function automatic logic [15:0] to_dac(input aopc_val_t v,
                                         input aopc_fmt_e f,
                                         input logic [15:0] lo,
                                         input logic [15:0] hi);
    logic signed [17:0] num;
    logic signed [17:0] den;
    logic [33:0] q;
    logic signed [17:0] t;
    num = 18'(v) - 18'($signed(lo));
    den = 18'($signed(hi)) - 18'($signed(lo));
    q = 34'(num[16:0]) * 34'(`AOPC_DAC_TOP);
    t = 18'(v) + 18'(`AOPC_OBIN_MID);
    if (f == aopc_f_scaled) begin
      if (num <= 0 || den <= 0) begin
        to_dac = 16'h0000;
      end else if (num >= den) begin
        to_dac = `AOPC_DAC_TOP;
      end else begin
        to_dac = 16'(q / 34'(den[16:0]));
      end
    end else if (t < 0) begin
      to_dac = 16'h0000;
    end else if (t > 18'sh0ffff) begin
      to_dac = `AOPC_DAC_TOP;
    end else begin
      to_dac = t[15:0];
    end
  endfunction

  // ==========================================================
  // Registers
  logic ack_ff;
  logic [31:0] dat_ff;
  logic [3:0] ctrl_ff;
  logic [`AOPC_ST_W-1:0] stat_ff;
  logic [`AOPC_ST_W-1:0] mask_ff;
  logic [6:0] cfg_ff [NCH];
  logic [15:0] upr_ff [NCH];
  logic [15:0] lwr_ff [NCH];
  logic [31:0] safe_ff [NCH];
  logic [15:0] word_ff [NCH];
  logic [15:0] dac_ff [NCH];
  logic [NCH-1:0] up_err_ff;
  logic [NCH-1:0] lo_err_ff;
  logic sc_err_ff;
  logic irq_ff;

  // ==========================================================
  // Bus decode; one wait state, unmapped reads return zero
  wire req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire wr = req & wb_we_i;
  wire [3:0] blk = wb_adr_i[7:4];
  wire [3:0] reg_off = wb_adr_i[3:0];
  wire ch_hit = blk >= `AOPC_CH_BASE && blk < `AOPC_CH_BASE + 4'(NCH);
  wire [3:0] chi = blk - `AOPC_CH_BASE;
  wire ch_sel = chi[0];
  wire wr_ctrl = wr && wb_adr_i == `AOPC_A_CTRL;
  wire wr_stat = wr && wb_adr_i == `AOPC_A_STAT;
  wire wr_mask = wr && wb_adr_i == `AOPC_A_MASK;
  wire [31:0] wdat = merge(32'h0, wb_dat_i, wb_sel_i);
  wire [31:0] nctl = merge({28'h0, ctrl_ff}, wb_dat_i, wb_sel_i);
  wire aopc_fmt_e fmt = aopc_fmt_e'(ctrl_ff[`AOPC_CTRL_FMT +: 2]);
  wire ht_prio = ctrl_ff[`AOPC_CTRL_HTPRIO];
  wire [`AOPC_ST_W-1:0] events = {lo_err_ff, up_err_ff, sc_err_ff};
  wire [`AOPC_ST_W-1:0] nxt_stat =
    (stat_ff & ~(wr_stat ? wdat[`AOPC_ST_W-1:0] : '0)) | events;

  logic [31:0] ch_rd;
  logic [31:0] nxt_dat;
  always_comb begin
    ch_rd = 32'h0;
    unique case (reg_off)
      `AOPC_O_CFG: ch_rd = {25'h0, cfg_ff[ch_sel]};
      `AOPC_O_UPR: ch_rd = {16'h0, upr_ff[ch_sel]};
      `AOPC_O_LWR: ch_rd = {16'h0, lwr_ff[ch_sel]};
      `AOPC_O_SAFE: ch_rd = safe_ff[ch_sel];
      default: ch_rd = 32'h0;
    endcase
    nxt_dat = 32'h0;
    if (ch_hit) begin
      nxt_dat = ch_rd;
    end else if (wb_adr_i == `AOPC_A_CTRL) begin
      nxt_dat = {28'h0, ctrl_ff};
    end else if (wb_adr_i == `AOPC_A_STAT) begin
      nxt_dat = {27'h0, stat_ff};
    end else if (wb_adr_i == `AOPC_A_MASK) begin
      nxt_dat = {27'h0, mask_ff};
    end else if (wb_adr_i == `AOPC_A_COMM) begin
      nxt_dat = {30'h0, comm_idle, comm_fault};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
      ctrl_ff <= `AOPC_CTRL_RST;
      stat_ff <= '0;
      mask_ff <= '0;
      irq_ff <= 1'b0;
      sc_err_ff <= 1'b0;
    end else begin
      ack_ff <= req;
      dat_ff <= req ? nxt_dat : 32'h0;
      if (wr_ctrl) begin
        ctrl_ff <= nctl[3:0];
      end
      if (wr_mask) begin
        mask_ff <= wdat[`AOPC_ST_W-1:0];
      end
      stat_ff <= nxt_stat;
      irq_ff <= |(stat_ff & mask_ff);
      sc_err_ff <= ctrl_ff[`AOPC_CTRL_SCMON] & sc_detect;
    end
  end

  // ==========================================================
  // Channels
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire wr_ch = wr && ch_hit && chi == 4'(c);
    wire use_flt = ht_prio & cfg_ff[c][`AOPC_CFG_FLTEN];
    wire use_idl = ht_prio & cfg_ff[c][`AOPC_CFG_IDLEN];
    wire [15:0] nxt_word = comm_fault ? (use_flt ? safe_ff[c][15:0]
                                                 : word_ff[c])
                         : comm_idle ? (use_idl ? safe_ff[c][31:16]
                                                : word_ff[c])
                         : plc_word[c];
    wire aopc_val_t val = to_val(word_ff[c], fmt);
    wire [31:0] nw = merge({16'h0, upr_ff[c]}, wb_dat_i, wb_sel_i);
    wire [31:0] nl = merge({16'h0, lwr_ff[c]}, wb_dat_i, wb_sel_i);
    wire [31:0] ncfg = merge({25'h0, cfg_ff[c]}, wb_dat_i, wb_sel_i);
    // Out-of-span limit writes saturate rather than wrap
    wire [15:0] nxt_upr = nw[15:0] == 16'h8000 ? `AOPC_UPR_MIN
                        : nw[15:0] == 16'h8001 ? `AOPC_UPR_MIN
                        : nw[15:0];
    wire [15:0] nxt_lwr = nl[15:0] == 16'h7fff ? `AOPC_LWR_MAX
                        : nl[15:0];
    always_ff @(posedge clk) begin
      if (rst) begin
        cfg_ff[c] <= `AOPC_CFG_RST;
        upr_ff[c] <= `AOPC_UPR_RST;
        lwr_ff[c] <= `AOPC_LWR_RST;
        safe_ff[c] <= 32'h0;
        word_ff[c] <= 16'h0;
        dac_ff[c] <= 16'h0;
        up_err_ff[c] <= 1'b0;
        lo_err_ff[c] <= 1'b0;
      end else begin
        if (wr_ch && reg_off == `AOPC_O_CFG) begin
          cfg_ff[c] <= ncfg[6:0];
        end
        if (wr_ch && reg_off == `AOPC_O_UPR) begin
          upr_ff[c] <= nxt_upr;
        end
        if (wr_ch && reg_off == `AOPC_O_LWR) begin
          lwr_ff[c] <= nxt_lwr;
        end
        if (wr_ch && reg_off == `AOPC_O_SAFE) begin
          safe_ff[c] <= merge(safe_ff[c], wb_dat_i, wb_sel_i);
        end
        word_ff[c] <= nxt_word;
        dac_ff[c] <= to_dac(val, fmt, lwr_ff[c], upr_ff[c]);
        up_err_ff[c] <= cfg_ff[c][`AOPC_CFG_UPEN] &&
                        val > 17'($signed(upr_ff[c]));
        lo_err_ff[c] <= cfg_ff[c][`AOPC_CFG_LOEN] &&
                        val < 17'($signed(lwr_ff[c]));
      end
    end
    assign dac_code[c] = dac_ff[c];
    assign ch_range[c] = cfg_ff[c][`AOPC_CFG_RANGE +: 3];
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign diag_unit = sc_err_ff;
  assign diag_upper = up_err_ff;
  assign diag_lower = lo_err_ff;
  assign irq = irq_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_cfg0_wr;
    wr && ch_hit && chi == 4'h0 && reg_off == `AOPC_O_CFG &&
    wb_sel_i[0];
  endsequence

  sequence s_fault_on;
    comm_fault && g_ch[0].use_flt;
  endsequence

  a_sc_error_gate: assert property (
    ctrl_ff[`AOPC_CTRL_SCMON] && sc_detect |=> diag_unit ##1 stat_ff[0]
  ) else $error("short not reported");
  a_sc_mon_off: assert property (
    !ctrl_ff[`AOPC_CTRL_SCMON] |=> !diag_unit
  ) else $error("short error while monitor off");
  a_range_write: assert property (
    s_cfg0_wr |=> ch_range[0] == $past(wb_dat_i[2:0])
  ) else $error("range not taken");
  a_obin_pass: assert property (
    fmt == aopc_f_obin |=> dac_code[0] == $past(word_ff[0])
  ) else $error("offset binary code wrong");
  a_upper_flag: assert property (
    cfg_ff[0][`AOPC_CFG_UPEN] && g_ch[0].val > 17'($signed(upr_ff[0]))
    |=> diag_upper[0] ##1 stat_ff[`AOPC_ST_UP]
  ) else $error("upper error missed");
  a_lower_flag: assert property (
    cfg_ff[0][`AOPC_CFG_LOEN] && g_ch[0].val < 17'($signed(lwr_ff[0]))
    |=> diag_lower[0] ##1 stat_ff[`AOPC_ST_LO]
  ) else $error("lower error missed");
  a_fault_value: assert property (
    s_fault_on |=> word_ff[0] == $past(safe_ff[0][15:0])
  ) else $error("fault value not driven");
  a_idle_value: assert property (
    !comm_fault && comm_idle && g_ch[0].use_idl
    |=> word_ff[0] == $past(safe_ff[0][31:16])
  ) else $error("idle value not driven");
  a_prio_hold: assert property (
    !ht_prio && (comm_fault || comm_idle) |=> $stable(word_ff[0])
  ) else $error("output moved without handheld priority");
  a_scaled_top: assert property (
    fmt == aopc_f_scaled && $signed(upr_ff[0]) > $signed(lwr_ff[0]) &&
    g_ch[0].val >= 17'($signed(upr_ff[0])) |=> dac_code[0] == 16'hffff
  ) else $error("scaled top not full code");
  a_irq_level: assert property (
    |(stat_ff & mask_ff) |=> irq
  ) else $error("interrupt not raised");
  // A held strobe must not be answered in two cycles in a row
  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o
  ) else $error("acknowledge longer than one cycle");
endmodule

// file: test/aopc_plc_model.sv
// Behavioural fieldbus master feeding output words and link state
`timescale 1ns/10ps
module aopc_plc_model (
  input wire logic clk, // Bench clock
  output logic [1:0][15:0] plc_word, // Words to the unit
  output logic comm_fault, // Link abnormal
  output logic comm_idle // Master idling
);
  logic [1:0][15:0] w_ff;
  logic tog_ff = 1'b0;
  initial begin
    w_ff = '0;
    comm_fault = 1'b0;
    comm_idle = 1'b0;
  end
  always @(posedge clk) tog_ff <= ~tog_ff;
  // A broken link carries garbage, never the last good word
  assign plc_word = comm_fault ? {2{tog_ff ? 16'h5a5a : 16'ha5a5}} : w_ff;
  task automatic send(input logic [15:0] w0, input logic [15:0] w1);
    @(posedge clk);
    w_ff <= {w1, w0};
  endtask
  task automatic link(input logic f, input logic i);
    @(posedge clk);
    comm_fault <= f;
    comm_idle <= i;
  endtask
endmodule

// file: test/analog_output_param_control_tb.sv
// Self-checking bench for the analogue output control block
`timescale 1ns/10ps
module analog_output_param_control_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sc = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rdata, dat_o;
  logic ack, dunit, irq, fault, idle;
  logic [1:0][15:0] word, dac;
  logic [1:0][2:0] rng;
  logic [1:0] dup, dlo;
  int n_mismatch = 0, checks = 0;
  always #10 clk = ~clk;
  aopc_core i_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .sc_detect(sc), .comm_fault(fault),
    .comm_idle(idle), .plc_word(word), .dac_code(dac), .ch_range(rng),
    .diag_unit(dunit), .diag_upper(dup), .diag_lower(dlo), .irq(irq));
  aopc_plc_model i_plc (.clk(clk), .plc_word(word), .comm_fault(fault),
    .comm_idle(idle));
  // ==========================================
  // Helpers
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  // Ack is sampled at a rising edge; the request stands until then
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      n_mismatch++;
      $display("FAIL wb_ack_o exp 1 got %b", ack);
      summarize();
    end else begin
      rdata = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      sel <= 4'h0;
    end
  endtask
  task automatic rd(input logic [7:0] a, input string nm,
                    input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, rdata);
  endtask
  task automatic wt();
    repeat (4) @(negedge clk);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    chk("ch_range", 32'h0, {26'h0, rng});
    rd(8'h00, "ctrl", 32'h1);
    rd(8'h10, "cfg0", 32'h0);
    rd(8'h14, "upper0", 32'h3e8);
    rd(8'h18, "lower0", 32'h0);
    rd(8'h08, "mask", 32'h0);
    rd(8'hf0, "unmapped", 32'h0);
    wb(1'b1, 8'h24, 32'h8000);
    wb(1'b0, 8'h24, 32'h0);
    chk("upper_sat", 32'h8002, {16'h0, rdata[15:0]});
    wb(1'b1, 8'h28, 32'h7fff);
    wb(1'b0, 8'h28, 32'h0);
    chk("lower_sat", 32'h7ffe, {16'h0, rdata[15:0]});
  endtask
  task automatic t_range();
    for (int r = 0; r < 5; r++) begin
      wb(1'b1, 8'h20, 32'(r));
      wt();
      chk("ch_range1", 32'(r), {29'h0, rng[1]});
    end
    wb(1'b1, 8'h20, 32'h0);
  endtask
  task automatic t_format();
    logic [31:0] ctl [5] = '{32'h1, 32'h5, 32'h3, 32'h7, 32'h7};
    logic [15:0] w [5] = '{16'h1234, 16'h0000, 16'h8005, 16'h00c8,
                           16'h03e8};
    logic [15:0] e [5] = '{16'h1234, 16'h8000, 16'h7ffb, 16'h3333,
                           16'hffff};
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, 8'h00, ctl[i]);
      i_plc.send(w[i], 16'h0);
      wt();
      chk("dac_code0", {16'h0, e[i]}, {16'h0, dac[0]});
    end
  endtask
  task automatic t_limits();
    wb(1'b1, 8'h00, 32'h5);
    wb(1'b1, 8'h14, 32'h0064);
    wb(1'b1, 8'h18, 32'hff9c);
    wb(1'b1, 8'h10, 32'h18);
    i_plc.send(16'h0065, 16'h7000);
    wt();
    chk("diag_up", 32'h1, {30'h0, dup});
    chk("diag_lo", 32'h0, {30'h0, dlo});
    rd(8'h04, "status", 32'h2);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wb(1'b1, 8'h08, 32'h1e);
    wt();
    chk("irq", 32'h1, {31'h0, irq});
    i_plc.send(16'hff9b, 16'h8000);
    wt();
    chk("diag_lo", 32'h1, {30'h0, dlo});
    wb(1'b1, 8'h04, 32'h2);
    rd(8'h04, "status_w1c", 32'h8);
    i_plc.send(16'h0064, 16'h0);
    wt();
    chk("diag_edge", 32'h0, {28'h0, dup, dlo});
    wb(1'b1, 8'h04, 32'h1e);
    wt();
    chk("irq_clear", 32'h0, {31'h0, irq});
  endtask
  task automatic t_short();
    @(posedge clk);
    sc <= 1'b1;
    wt();
    chk("diag_unit", 32'h1, {31'h0, dunit});
    wb(1'b1, 8'h00, 32'h4);
    wt();
    chk("diag_unit_off", 32'h0, {31'h0, dunit});
    @(posedge clk);
    sc <= 1'b0;
  endtask
  task automatic t_safe();
    wb(1'b1, 8'h00, 32'h9);
    wb(1'b1, 8'h10, 32'h60);
    wb(1'b1, 8'h1c, 32'h0def0abc);
    i_plc.send(16'h1111, 16'h2222);
    i_plc.link(1'b1, 1'b0);
    wt();
    chk("dac_fault", 32'h22220abc, dac);
    i_plc.link(1'b0, 1'b1);
    wt();
    chk("dac_idle", 32'h22220def, dac);
    i_plc.link(1'b0, 1'b0);
    wb(1'b1, 8'h00, 32'h1);
    i_plc.link(1'b1, 1'b0);
    wt();
    chk("dac_noprio", 32'h22221111, dac);
    i_plc.link(1'b0, 1'b0);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    $display("reset test done");
    t_range();
    $display("range test done");
    t_format();
    $display("format test done");
    t_limits();
    $display("limits test done");
    t_short();
    $display("short test done");
    t_safe();
    $display("safe value test done");
    summarize();
  end
endmodule
